// [sas_sequencer.sv]
/*
 SAR converter sequencer: start delay, sample and hold timing, bit trial
 loop and result loading.
 Assumes the comparator output comes from core_clk logic in the front
 end and settles within one clock of a new trial code.
*/
`timescale 1ns/1ps
module sas_sequencer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control bits
  input wire logic conversion_run_bit,
  input wire logic comparator_enable,
  input wire logic [2:0] time_select,
  input wire logic [1:0] input_channel_select,
  // Analog front end
  input wire logic comparator_out,
  output logic [3:0] analog_select_r,
  output logic [3:0] port_free_r,
  output logic sample_r,
  output logic hold_r,
  output logic comp_on_r,
  output logic [9:0] dac_code_r,
  // Results
  output logic [15:0] result_word_r,
  output logic [7:0] result_high_byte_r,
  output logic first_invalid_r,
  output logic conversion_done_irq_r
);
  // Sample clocks per time-select code
  function automatic logic [7:0] samp_clks(input logic [2:0] c);
    unique case (c)
      3'h0: samp_clks = 8'h0C;
      3'h4: samp_clks = 8'h18;
      3'h6: samp_clks = 8'h60;
      3'h5: samp_clks = 8'h30;
      3'h2: samp_clks = 8'h30;
      3'h1: samp_clks = 8'h18;
      3'h7: samp_clks = 8'hB0;
      3'h3: samp_clks = 8'h58;
    endcase
  endfunction
  // Total clocks per code
  function automatic logic [7:0] total_clks(input logic [2:0] c);
    unique case (c)
      3'h0: total_clks = 8'h24;
      3'h4: total_clks = 8'h48;
      3'h6: total_clks = 8'h90;
      3'h5: total_clks = 8'h60;
      3'h2: total_clks = 8'h48;
      3'h1: total_clks = 8'h30;
      3'h7: total_clks = 8'hE0;
      3'h3: total_clks = 8'h70;
    endcase
  endfunction

  // Comparator is strobed on core_clk, so it is read directly; a pin
  // synchroniser would not fit inside a two-clock trial step [R15]

  sas_pkg::sas_state_e state_r;
  logic [7:0] cnt_r;
  logic [7:0] step_len_r;
  logic [3:0] bit_r;
  logic [9:0] sar_r;
  logic [2:0] tsel_r;
  logic step_end;
  assign step_end = (cnt_r == step_len_r);

  // Trial step length: remaining clocks spread over ten bit trials [R05]
  logic [7:0] cmp_clks;
  assign cmp_clks = total_clks(tsel_r) - samp_clks(tsel_r);
  logic [7:0] step_clks;
  assign step_clks = cmp_clks / 8'h0A;
  // Last trial takes the remainder so the period matches the code [R04]
  logic [7:0] last_clks;
  assign last_clks = cmp_clks - 8'(step_clks * 8'h09);

  // Sequencing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= sas_pkg::SAS_IDLE;
      cnt_r <= sas_pkg::CNT_RESET;
      step_len_r <= sas_pkg::CNT_RESET;
      bit_r <= 4'h0;
      sar_r <= 10'h000;
      tsel_r <= 3'h0;
    end else if (!conversion_run_bit) begin
      state_r <= sas_pkg::SAS_IDLE; // [R16]
      cnt_r <= sas_pkg::CNT_RESET;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      unique case (state_r)
        sas_pkg::SAS_IDLE: begin
          state_r <= sas_pkg::SAS_DELAY;
          cnt_r <= 8'h00;
          step_len_r <= {6'h00, sas_pkg::START_DELAY} - 8'h01;
        end
        sas_pkg::SAS_DELAY: begin
          if (step_end) begin
            state_r <= sas_pkg::SAS_SAMPLE; // [R03]
            cnt_r <= 8'h00;
            tsel_r <= time_select;
            step_len_r <= samp_clks(time_select) - 8'h01; // [R04]
          end
        end
        sas_pkg::SAS_SAMPLE: begin
          if (step_end) begin
            state_r <= sas_pkg::SAS_COMPARE;
            cnt_r <= 8'h00;
            bit_r <= 4'h9;
            sar_r <= 10'h200; // [R15]
            step_len_r <= step_clks - 8'h01;
          end
        end
        sas_pkg::SAS_COMPARE: begin
          if (step_end) begin
            cnt_r <= 8'h00;
            // Keep the trial bit when input is at or above the DAC level [R15]
            if (!comparator_out) begin
              sar_r[bit_r] <= 1'b0;
            end
            if (bit_r == 4'h0) begin
              // Back to sampling on the same channel [R01]
              state_r <= sas_pkg::SAS_SAMPLE;
              tsel_r <= time_select;
              step_len_r <= samp_clks(time_select) - 8'h01;
            end else begin
              bit_r <= bit_r - 4'h1;
              sar_r[bit_r - 4'h1] <= 1'b1;
              if (bit_r == 4'h1) begin
                step_len_r <= last_clks - 8'h01; // [R04]
              end
            end
          end
        end
      endcase
    end
  end

  logic conv_end;
  assign conv_end = conversion_run_bit && state_r == sas_pkg::SAS_COMPARE &&
                    step_end && bit_r == 4'h0;
  logic [9:0] final_code;
  assign final_code = comparator_out ? sar_r : (sar_r & 10'h3FE);

  // Results and done pulse
  logic comp_seen_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_word_r <= sas_pkg::RESULT_RESET;
      result_high_byte_r <= 8'h00;
      conversion_done_irq_r <= 1'b0;
      first_invalid_r <= 1'b0;
      comp_seen_r <= 1'b0;
    end else begin
      conversion_done_irq_r <= conv_end; // [R02]
      if (state_r == sas_pkg::SAS_IDLE) begin
        comp_seen_r <= comparator_enable;
      end
      if (conv_end) begin
        result_word_r <= {6'h00, final_code}; // [R13]
        result_high_byte_r <= final_code[9:2]; // [R14]
        // Flag a result taken with comparator off at start [R12]
        first_invalid_r <= !comp_seen_r;
        comp_seen_r <= 1'b1;
      end
    end
  end

  // Front-end controls; the mux only grabs the selected pin [R11]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      analog_select_r <= 4'h0;
      port_free_r <= 4'hF;
      sample_r <= 1'b0;
      hold_r <= 1'b0;
      comp_on_r <= 1'b0;
      dac_code_r <= 10'h000;
    end else begin
      analog_select_r <= conversion_run_bit ?
                         (4'h1 << input_channel_select) : 4'h0; // [R01]
      port_free_r <= conversion_run_bit ?
                     ~(4'h1 << input_channel_select) : 4'hF; // [R11]
      sample_r <= conversion_run_bit && state_r == sas_pkg::SAS_SAMPLE;
      hold_r <= conversion_run_bit &&
                state_r == sas_pkg::SAS_COMPARE && !conv_end; // [R10]
      comp_on_r <= comparator_enable;
      dac_code_r <= sar_r;
    end
  end

  a_start_delay: assert property ( // [R03]
    @(posedge core_clk) disable iff (!rst_n)
    $rose(conversion_run_bit) ##1 conversion_run_bit[*3] |=>
    sample_r || !conversion_run_bit)
    else $error("sampling did not start after run rise");
  a_done_pulse: assert property ( // [R02]
    @(posedge core_clk) disable iff (!rst_n)
    conversion_done_irq_r |=> !conversion_done_irq_r)
    else $error("done request longer than one cycle");
  a_result_zero: assert property ( // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    result_word_r[15:10] == 6'h00)
    else $error("result upper bits not zero");
  a_high_byte: assert property ( // [R14]
    @(posedge core_clk) disable iff (!rst_n)
    conversion_done_irq_r |-> result_high_byte_r == result_word_r[9:2])
    else $error("high byte mismatch");
  a_abandon: assert property ( // [R16]
    @(posedge core_clk) disable iff (!rst_n)
    !conversion_run_bit |=> !conversion_done_irq_r && $stable(result_word_r))
    else $error("abandoned conversion updated results");
  a_hold_span: assert property ( // [R10]
    @(posedge core_clk) disable iff (!rst_n)
    conversion_done_irq_r |-> !hold_r)
    else $error("hold not released at done");
  a_port_free: assert property ( // [R11]
    @(posedge core_clk) disable iff (!rst_n)
    (analog_select_r & port_free_r) == 4'h0)
    else $error("selected pin also free");
  a_sample_next: assert property ( // [R01]
    @(posedge core_clk) disable iff (!rst_n)
    conversion_done_irq_r && conversion_run_bit |=> sample_r)
    else $error("no resample after done");
  c_done: cover property (@(posedge core_clk) conversion_done_irq_r);
  c_repeat: cover property (@(posedge core_clk)
    conversion_done_irq_r ##[1:300] conversion_done_irq_r);
  c_abort: cover property (@(posedge core_clk)
    hold_r ##1 !conversion_run_bit);
  c_first_invalid: cover property (@(posedge core_clk)
    conversion_done_irq_r && first_invalid_r);
endmodule

// [sas_pkg.sv]
/*
 Constants and types for the SAR converter sequencer.
 Assumes one 200 MHz peripheral clock and a synchronous low reset.
*/
// Functional notes
// R01: Convert the selected one of four channels at 10 bits, repeatedly while enabled.
// R02: Pulse the done request once at the end of every completed conversion.
// R03: Sampling begins two or three clocks after the run bit rises.
// R04: Sample and total clock counts come from the three-bit time-select field.
// R05: Sampling time counts inside the total conversion period.
// R06: Software keeps the total conversion period under the upper limit.
// R07: Software keeps sampling time above the supply-dependent minimum.
// R08: Software avoids codes 001 and 011 at a 10 MHz clock.
// R09: Software leaves margin for clock error up to five percent.
// R10: Hold the sampled input from conversion start until conversion ends.
// R11: Unselected analog pins stay free for port use.
// R12: Run starts even without comparator enable; first result is then invalid.
// R13: Result word holds the 10-bit result low, upper six bits zero.
// R14: Result high byte holds the upper eight result bits.
// R15: Resolve one bit per step, MSB first, ending at LSB.
// R16: Clearing run abandons a conversion without results or done request.
package sas_pkg;
  localparam int RES_BITS = 10;
  localparam int CH_NUM = 4;
  localparam logic [1:0] START_DELAY = 2'h2;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_DELAY = 2'b01,
    SAS_SAMPLE = 2'b10,
    SAS_COMPARE = 2'b11
  } sas_state_e;
endpackage

// [sas_front_model.sv]
/*
 Analog front end model: pin selector, sample and hold, DAC compare.
 Assumes selects, sample strobe and trial code come from the sequencer.
*/
`timescale 1ns/1ps
module sas_front_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic [3:0] analog_select_r,
  input wire logic sample_r,
  input wire logic comp_on_r,
  input wire logic [9:0] dac_code_r,
  // Pins and comparator
  input wire logic [39:0] pin_level,
  output logic comparator_out
);
  logic [9:0] held_r = 10'h000;
  logic junk_r = 1'b0;
  always @(posedge core_clk) begin
    junk_r <= ~junk_r;
    for (int i = 0; i < 4; i++)
      if (sample_r && analog_select_r[i])
        held_r <= pin_level[i*10 +: 10];
  end
  // Stopped comparator toggles, so its result is garbage
  assign comparator_out = comp_on_r ? (held_r >= dac_code_r) : junk_r;
endmodule

// [testbench.sv]
/*
 Self-checking bench for the converter sequencer.
 Assumes sas_front_model stands for the analog side.
*/
`timescale 1ns/1ps
module testbench;
  localparam int SMP[8] = '{12, 24, 48, 88, 24, 48, 96, 176};
  localparam int TOT[8] = '{36, 48, 72, 112, 72, 96, 144, 224};
  logic core_clk = 0, rst_n = 0, run = 0, cen = 1, cout, smp, hld, con;
  logic inv, done;
  logic [2:0] tsel = 0;
  logic [1:0] ch = 0;
  logic [39:0] pins = 0;
  logic [3:0] asel, pfree;
  logic [9:0] dac;
  logic [15:0] rw;
  logic [7:0] rh;
  logic [10:0] e;
  logic [10:0] expq[$];
  logic [9:0] prev_res;
  logic [31:0] rng = 33719;
  int error_cnt = 0, checks = 0;

  sas_sequencer u_sas_sequencer (.core_clk(core_clk), .rst_n(rst_n),
    .conversion_run_bit(run), .comparator_enable(cen), .time_select(tsel),
    .input_channel_select(ch), .comparator_out(cout),
    .analog_select_r(asel), .port_free_r(pfree), .sample_r(smp),
    .hold_r(hld), .comp_on_r(con), .dac_code_r(dac),
    .result_word_r(rw), .result_high_byte_r(rh),
    .first_invalid_r(inv), .conversion_done_irq_r(done));
  sas_front_model u_sas_front_model (.core_clk(core_clk),
    .analog_select_r(asel), .sample_r(smp), .comp_on_r(con),
    .dac_code_r(dac), .pin_level(pins), .comparator_out(cout));

  initial forever #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Results are judged a step after the edge so they have settled
  always @(posedge core_clk) #1 if (rst_n && done === 1'b1) begin
    if (expq.size() == 0) chk({15'h0, done}, 16'h0);
    else begin
      e = expq.pop_front();
      chk({15'h0, inv}, {15'h0, e[10]});
      if (!e[10]) chk(rw, {6'h0, e[9:0]});
      if (!e[10]) chk({8'h0, rh}, {8'h0, e[9:2]});
    end
  end

  task automatic conv(input logic [2:0] ts, input logic [1:0] c,
                      input logic off);
    int n, g;
    logic [31:0] r;
    begin
      r = xs();
      pins[39:20] = r[19:0];
      r = xs();
      pins[19:0] = r[31:12];
      tsel = ts;
      ch = c;
      cen = ~off;
      expq.push_back({off, pins[c*10 +: 10]});
      expq.push_back({1'b0, pins[c*10 +: 10]});
      run = 1;
      n = 0;
      while (smp !== 1'b1 && n < 9) begin
        @(negedge core_clk);
        n++;
      end
      chk({15'h0, n >= 2 && n <= 4}, 16'h1);
      cen = 1;
      chk({12'h0, asel}, {12'h0, 4'h1 << c});
      chk({12'h0, pfree}, {12'h0, ~(4'h1 << c)});
      n = 0;
      while (done !== 1'b1 && n < 300) begin
        @(negedge core_clk);
        n++;
      end
      chk({15'h0, done}, 16'h1);
      g = 1;
      @(negedge core_clk);
      while (done !== 1'b1 && g < 300) begin
        @(negedge core_clk);
        g++;
      end
      chk({15'h0, g > SMP[ts] && g == TOT[ts]}, 16'h1);
      run = 0;
      chk(16'(expq.size()), 16'h0);
      @(negedge core_clk);
    end
  endtask

  task automatic results();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    @(negedge core_clk);
    // All codes are legal at this clock and leave margin for clock error
    for (int i = 0; i < 8; i++) conv(3'(i), 2'(i), i == 3);
    // Abort inside the bit trials: no done pulse and no result update
    prev_res = pins[ch*10 +: 10];
    pins = ~pins;
    tsel = 3'h0;
    run = 1;
    repeat (25) @(negedge core_clk);
    chk({15'h0, hld}, 16'h1);
    run = 0;
    repeat (300) @(negedge core_clk);
    chk(rw, {6'h0, prev_res});
    results();
  end

  // Whole run needs about 10 us; hang cut-off well beyond
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule
